// [ccf_pkg.sv]
// Package of constants and types for the processor flag word block.
package ccf_pkg;

  // ****************************************************************
  // Flag word layout
  // ****************************************************************
  localparam int unsigned FLAG_WIDTH   = 8;
  localparam int unsigned BIT_WRAP     = 0;
  localparam int unsigned BIT_ZERO     = 1;
  localparam int unsigned BIT_SIGN     = 2;
  localparam int unsigned BIT_PRIO_LO  = 3;
  localparam int unsigned BIT_NIB      = 4;
  localparam int unsigned BIT_PRIO_HI  = 5;
  localparam logic [7:0]  FLAG_WORD_RST = 8'hE8;
  localparam logic [7:0]  FLAG_WR_MASK  = 8'h3F;

  // ****************************************************************
  // Priority encodings (upper:lower)
  // ****************************************************************
  localparam logic [1:0] PRIO_LVL0 = 2'h2;
  localparam logic [1:0] PRIO_LVL1 = 2'h1;
  localparam logic [1:0] PRIO_LVL2 = 2'h0;
  localparam logic [1:0] PRIO_LVL3 = 2'h3;

  // ****************************************************************
  // Operations and branch conditions
  // ****************************************************************
  typedef enum logic [3:0] {
    CCF_OP_NONE,
    CCF_OP_ADD,
    CCF_OP_ADC,
    CCF_OP_SUB,
    CCF_OP_LOGIC,
    CCF_OP_SHIFT,
    CCF_OP_BTJ,
    CCF_OP_SET_WRAP,
    CCF_OP_CLR_WRAP,
    CCF_OP_POP,
    CCF_OP_MAIN_LVL,
    CCF_OP_MASK_ALL,
    CCF_OP_IRQ_RET,
    CCF_OP_HALT,
    CCF_OP_WAIT_IRQ,
    CCF_OP_IRQ_ENTRY
  } ccf_op_e;

  typedef enum logic [3:0] {
    CCF_BR_NIB_OVF,
    CCF_BR_NO_NIB_OVF,
    CCF_BR_MINUS,
    CCF_BR_PLUS,
    CCF_BR_EQUAL,
    CCF_BR_NOT_EQUAL,
    CCF_BR_WRAP,
    CCF_BR_NO_WRAP,
    CCF_BR_LVL3,
    CCF_BR_NOT_LVL3
  } ccf_br_e;

endpackage

// [ccf_branch_eval.sv]
// Branch condition evaluator reading the flag word.
`timescale 1ns/10ps
module ccf_branch_eval
  import ccf_pkg::*;
(
  // Flag word and selected condition
  input  wire logic [7:0] flag_word,
  input  wire ccf_br_e    br_sel,
  // Decision
  output logic            br_taken
);

  always_comb begin
    br_taken = 1'b0;
    unique case (br_sel)
      CCF_BR_NIB_OVF:    br_taken = flag_word[BIT_NIB];    // [RQ4]
      CCF_BR_NO_NIB_OVF: br_taken = !flag_word[BIT_NIB];   // [RQ4]
      CCF_BR_MINUS:      br_taken = flag_word[BIT_SIGN];   // [RQ6]
      CCF_BR_PLUS:       br_taken = !flag_word[BIT_SIGN];  // [RQ6]
      CCF_BR_EQUAL:      br_taken = flag_word[BIT_ZERO];   // [RQ8]
      CCF_BR_NOT_EQUAL:  br_taken = !flag_word[BIT_ZERO];  // [RQ8]
      CCF_BR_WRAP:       br_taken = flag_word[BIT_WRAP];   // [RQ10]
      CCF_BR_NO_WRAP:    br_taken = !flag_word[BIT_WRAP];  // [RQ10]
      CCF_BR_LVL3:       br_taken = {flag_word[BIT_PRIO_HI], flag_word[BIT_PRIO_LO]} == PRIO_LVL3;
      CCF_BR_NOT_LVL3:   br_taken = {flag_word[BIT_PRIO_HI], flag_word[BIT_PRIO_LO]} != PRIO_LVL3;
      default:           br_taken = 1'b0;
    endcase
  end

endmodule

// [ccf_flag_word.sv]
// Processor flag word: result flags, software priority and branch decisions.
`timescale 1ns/10ps
// What this block does
// [RQ1] Eight-bit word, priority plus four flags
// [RQ2] Push reads word, pop overwrites writable bits
// [RQ3] Add carries bit 3 into nibble flag
// [RQ4] Nibble flag branches on set or clear
// [RQ5] Sign flag copies result bit 7
// [RQ6] Minus and plus branches test sign
// [RQ7] Zero flag set on zero result
// [RQ8] Equal and not-equal branches test zero
// [RQ9] Wrap flag follows arithmetic overflow or underflow
// [RQ10] Wrap set, clear and branch instructions
// [RQ11] Bit-test, shift, rotate update wrap flag
// [RQ12] Priority bits at positions five and three
// [RQ13] Encodings 10,01,00,11; level three masks
// [RQ14] Interrupt entry loads priority from registers
// [RQ15] Priority-changing instructions rewrite priority bits
// [RQ16] Reset leaves priority at level three
module ccf_flag_word
  import ccf_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = FLAG_WIDTH
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Operation from the sequencer and ALU
  input  wire logic            op_valid,
  input  wire ccf_op_e         op_code,
  input  wire logic [7:0]      alu_result,
  input  wire logic            alu_carry_out,
  input  wire logic            alu_nib_carry,
  input  wire logic            bit_test_value,
  // Stack pop data and priority from the soft_priority_regs
  input  wire logic [7:0]      pop_data,
  input  wire logic [1:0]      irq_prio_level,
  // Branch request
  input  wire ccf_br_e         br_sel,
  // Flag word state and branch decision
  output logic [7:0]           flag_word,
  output logic                 br_taken,
  output logic                 irq_masked
);

  // ****************************************************************
  // Parameter and constant checks
  // ****************************************************************
  // The flag positions are placed by hand in the package, so a slip there
  // would make two flags share a bit without any other symptom.
  localparam logic [7:0] LAYOUT_MASK = (8'h01 << BIT_WRAP) | (8'h01 << BIT_ZERO) | (8'h01 << BIT_SIGN) |
                                       (8'h01 << BIT_PRIO_LO) | (8'h01 << BIT_NIB) | (8'h01 << BIT_PRIO_HI);

  if (DATA_WIDTH != FLAG_WIDTH) begin : g_bad_width
    $error("ccf_flag_word supports only an eight-bit flag word");
  end

  if ($countones(LAYOUT_MASK) != 6) begin : g_bad_layout
    $error("ccf_flag_word needs six distinct flag positions");
  end

  // A pop must be able to rewrite every defined bit and nothing else.
  if (LAYOUT_MASK != FLAG_WR_MASK) begin : g_bad_mask
    $error("ccf_flag_word writable mask must match the flag layout");
  end

  // Interrupts must stay masked until software lowers the priority.
  if ({FLAG_WORD_RST[BIT_PRIO_HI], FLAG_WORD_RST[BIT_PRIO_LO]} != PRIO_LVL3) begin : g_bad_rst_prio
    $error("ccf_flag_word must leave reset at priority level three");
  end

  // The two spare bits are never written, so they keep their reset value.
  if ((FLAG_WORD_RST | FLAG_WR_MASK) != 8'hFF) begin : g_bad_rst_spare
    $error("ccf_flag_word spare bits must reset to one");
  end

  // ****************************************************************
  // Flag word state
  // ****************************************************************
  logic [7:0] flag_word_reg;
  logic [7:0] flag_word_next;
  logic       br_taken_reg;
  logic       br_taken_next;
  logic       irq_masked_reg;
  logic       irq_masked_next;

  // ****************************************************************
  // Field helpers
  // ****************************************************************
  // Writes a priority level into its two scattered bit positions.
  function automatic logic [7:0] set_prio(input logic [7:0] w, input logic [1:0] lvl);
    logic [7:0] r;
    r = w;
    r[BIT_PRIO_HI] = lvl[1];  // [RQ12]
    r[BIT_PRIO_LO] = lvl[0];  // [RQ12]
    return r;
  endfunction

  // Sign and zero follow the result byte of every data operation.
  function automatic logic [7:0] set_result(input logic [7:0] w, input logic [7:0] res);
    logic [7:0] r;
    r = w;
    r[BIT_SIGN] = res[7];         // [RQ5]
    r[BIT_ZERO] = (res == 8'h00); // [RQ7]
    return r;
  endfunction

  // Reads the two priority bits back as one upper:lower level code.
  function automatic logic [1:0] prio_of(input logic [7:0] w);
    return {w[BIT_PRIO_HI], w[BIT_PRIO_LO]};  // [RQ12]
  endfunction

  // ****************************************************************
  // Next flag word
  // ****************************************************************
  // Only one operation is applied per edge; the sequencer never asks for
  // two, so there is no precedence between op codes to resolve here.
  always_comb begin
    flag_word_next = flag_word_reg;
    if (op_valid) begin
      unique case (op_code)
        CCF_OP_NONE: begin
          // A bubble from the sequencer leaves every flag as it was.
          flag_word_next = flag_word_reg;
        end
        CCF_OP_ADD, CCF_OP_ADC: begin
          flag_word_next           = set_result(flag_word_reg, alu_result);
          flag_word_next[BIT_NIB]  = alu_nib_carry;  // [RQ3]
          flag_word_next[BIT_WRAP] = alu_carry_out;  // [RQ9]
        end
        CCF_OP_SUB: begin
          // The nibble flag only has meaning for adds, so a subtract keeps it.
          flag_word_next           = set_result(flag_word_reg, alu_result);
          flag_word_next[BIT_WRAP] = alu_carry_out;  // [RQ9]
        end
        CCF_OP_LOGIC: begin
          // Logical results have no carry, so the wrap flag is kept.
          flag_word_next = set_result(flag_word_reg, alu_result);
        end
        CCF_OP_SHIFT: begin
          flag_word_next           = set_result(flag_word_reg, alu_result);
          flag_word_next[BIT_WRAP] = alu_carry_out;  // [RQ11]
        end
        CCF_OP_BTJ: begin
          // The tested bit lands in the wrap flag; nothing else moves.
          flag_word_next[BIT_WRAP] = bit_test_value;  // [RQ11]
        end
        CCF_OP_SET_WRAP: begin
          flag_word_next[BIT_WRAP] = 1'b1;  // [RQ10]
        end
        CCF_OP_CLR_WRAP: begin
          flag_word_next[BIT_WRAP] = 1'b0;  // [RQ10]
        end
        CCF_OP_POP, CCF_OP_IRQ_RET: begin
          // Bits 7:6 always read as one, so only the low six are written.
          flag_word_next = (flag_word_reg & ~FLAG_WR_MASK) | (pop_data & FLAG_WR_MASK);  // [RQ2] [RQ15]
        end
        CCF_OP_MAIN_LVL, CCF_OP_HALT, CCF_OP_WAIT_IRQ: begin
          flag_word_next = set_prio(flag_word_reg, PRIO_LVL0);  // [RQ15] [RQ13]
        end
        CCF_OP_MASK_ALL: begin
          flag_word_next = set_prio(flag_word_reg, PRIO_LVL3);  // [RQ15] [RQ13]
        end
        CCF_OP_IRQ_ENTRY: begin
          flag_word_next = set_prio(flag_word_reg, irq_prio_level);  // [RQ14]
        end
      endcase
    end
  end

  // ****************************************************************
  // Branch decision
  // ****************************************************************
  // The branch decision looks at the registered word, so a branch in the
  // same cycle as an update sees the value before that update. Taking the
  // next value instead would save a cycle but would put the whole update
  // path in front of the branch logic.
  ccf_branch_eval u_branch_eval (
    .flag_word (flag_word_reg),
    .br_sel    (br_sel),
    .br_taken  (br_taken_next)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      br_taken_reg <= 1'b0;
    end else begin
      br_taken_reg <= br_taken_next;
    end
  end

  // ****************************************************************
  // Interrupt mask
  // ****************************************************************
  // The mask is taken from the next word, so it always agrees with the
  // registered priority bits in the same cycle.
  always_comb begin
    irq_masked_next = (prio_of(flag_word_next) == PRIO_LVL3);  // [RQ13]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_masked_reg <= 1'b1;  // [RQ16]
    end else begin
      irq_masked_reg <= irq_masked_next;
    end
  end

  // ****************************************************************
  // Flag word register
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_word_reg <= FLAG_WORD_RST;  // [RQ16]
    end else begin
      flag_word_reg <= flag_word_next;  // [RQ1]
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign flag_word  = flag_word_reg;
  assign br_taken   = br_taken_reg;
  assign irq_masked = irq_masked_reg;

endmodule

// [ccf_alu_model.sv]
// Arithmetic unit model that feeds results and carries to the flag word.
`timescale 1ns/10ps
module ccf_alu_model
  import ccf_pkg::*;
(
  // Operation and operands
  input  wire ccf_op_e    op_code,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic       cin,
  // Results
  output logic [7:0]      res,
  output logic            cout,
  output logic            nib
);
  logic [8:0] s;
  always_comb begin
    case (op_code)
      CCF_OP_SUB:   s = {1'b0, opa} - {1'b0, opb};
      CCF_OP_SHIFT: s = {opa, 1'b0};
      CCF_OP_LOGIC: s = {1'b0, opa & opb};
      default:      s = {1'b0, opa} + {1'b0, opb} + {8'h00, cin && op_code == CCF_OP_ADC};
    endcase
    res = s[7:0];
    cout = s[8];
    // The carry into bit 4 is recovered from the sum, so no second adder is needed.
    nib = s[4] ^ opa[4] ^ opb[4];
  end
endmodule

// [ccf_flag_word_props.sv]
// Checker of the flag word port behaviour.
`timescale 1ns/10ps
module ccf_flag_word_props
  import ccf_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Operation and branch inputs
  input wire logic       op_valid,
  input wire ccf_op_e    op_code,
  input wire logic [7:0] alu_result,
  input wire logic       alu_carry_out,
  input wire logic       alu_nib_carry,
  input wire logic       bit_test_value,
  input wire logic [7:0] pop_data,
  input wire logic [1:0] irq_prio_level,
  input wire ccf_br_e    br_sel,
  // Watched outputs
  input wire logic [7:0] flag_word,
  input wire logic       br_taken,
  input wire logic       irq_masked
);
  logic ar;
  logic lower_op;
  assign ar = op_valid && op_code inside {CCF_OP_ADD, CCF_OP_ADC, CCF_OP_SUB, CCF_OP_SHIFT};
  assign lower_op = op_valid && op_code inside {CCF_OP_MAIN_LVL, CCF_OP_HALT, CCF_OP_WAIT_IRQ};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  idle_hold_a: assert property (!op_valid |=> $stable(flag_word))
    else $error("word moved while idle");
  sign_zero_a: assert property (ar |=> flag_word[2:1] == {$past(alu_result[7]), $past(alu_result) == 8'h00})
    else $error("sign or zero wrong");
  nib_carry_a: assert property (ar && op_code != CCF_OP_SUB && op_code != CCF_OP_SHIFT |=>
      flag_word[4] == $past(alu_nib_carry))
    else $error("nibble flag wrong");
  wrap_arith_a: assert property (ar |=> flag_word[0] == $past(alu_carry_out))
    else $error("wrap flag wrong");
  pop_load_a: assert property (op_valid && op_code == CCF_OP_POP |=> flag_word[5:0] == $past(pop_data[5:0]))
    else $error("pop not loaded");
  irq_entry_a: assert property (op_valid && op_code == CCF_OP_IRQ_ENTRY |=>
      {flag_word[5], flag_word[3]} == $past(irq_prio_level))
    else $error("entry priority wrong");
  mask_level_a: assert property (irq_masked == (flag_word[5] && flag_word[3]))
    else $error("mask level wrong");
  br_equal_a: assert property (br_sel == CCF_BR_EQUAL |=> br_taken == $past(flag_word[1]))
    else $error("equal branch wrong");
  mask_all_a: assert property (op_valid && op_code == CCF_OP_MASK_ALL |=>
      irq_masked && {flag_word[5], flag_word[3]} == PRIO_LVL3)
    else $error("mask all not applied");
  main_level_a: assert property (lower_op |=>
      !irq_masked && {flag_word[5], flag_word[3]} == PRIO_LVL0)
    else $error("main level not applied");
  wrap_force_a: assert property (op_valid && op_code inside {CCF_OP_SET_WRAP, CCF_OP_CLR_WRAP} |=>
      flag_word[0] == ($past(op_code) == CCF_OP_SET_WRAP))
    else $error("wrap set or clear wrong");
  bit_test_a: assert property (op_valid && op_code == CCF_OP_BTJ |=>
      flag_word == {$past(flag_word[7:1]), $past(bit_test_value)})
    else $error("bit test wrap wrong");
  reset_state_a: assert property (disable iff (1'b0) rst |=>
      flag_word == FLAG_WORD_RST && irq_masked && !br_taken)
    else $error("reset state wrong");
  cover property (op_valid && op_code == CCF_OP_IRQ_ENTRY);
  cover property (op_valid && op_code == CCF_OP_POP);
  cover property (br_taken);
  cover property (irq_masked ##1 !irq_masked);
endmodule
bind ccf_flag_word ccf_flag_word_props i_ccf_flag_word_props (
  .core_clk       (core_clk),
  .rst            (rst),
  .op_valid       (op_valid),
  .op_code        (op_code),
  .alu_result     (alu_result),
  .alu_carry_out  (alu_carry_out),
  .alu_nib_carry  (alu_nib_carry),
  .bit_test_value (bit_test_value),
  .pop_data       (pop_data),
  .irq_prio_level (irq_prio_level),
  .br_sel         (br_sel),
  .flag_word      (flag_word),
  .br_taken       (br_taken),
  .irq_masked     (irq_masked)
);

// [ccf_flag_word_test.sv]
// Self-checking bench comparing the flag word with a behavioural model.
`timescale 1ns/10ps
module ccf_flag_word_test
  import ccf_pkg::*;
;
  logic        core_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, bit_test_value = 1'b0, exp_b = 1'b0;
  logic        alu_carry_out, alu_nib_carry, br_taken, irq_masked;
  logic [7:0]  opa = 8'h00, opb = 8'h00, pop_data = 8'h00, alu_result, flag_word, exp_w = FLAG_WORD_RST;
  logic [1:0]  irq_prio_level = 2'h0;
  logic [31:0] seed = 32'h0000_f2eb;
  ccf_op_e     op_code = CCF_OP_NONE;
  ccf_br_e     br_sel = CCF_BR_EQUAL;
  int          n_errors = 0, cmp_count = 0;
  ccf_alu_model i_ccf_alu_model (.op_code(op_code), .opa(opa), .opb(opb), .cin(flag_word[0]), .res(alu_result),
    .cout(alu_carry_out), .nib(alu_nib_carry));
  ccf_flag_word i_ccf_flag_word (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .alu_result(alu_result), .alu_carry_out(alu_carry_out), .alu_nib_carry(alu_nib_carry),
    .bit_test_value(bit_test_value), .pop_data(pop_data), .irq_prio_level(irq_prio_level), .br_sel(br_sel),
    .flag_word(flag_word), .br_taken(br_taken), .irq_masked(irq_masked));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic brf(input logic [7:0] w, input ccf_br_e s);
    logic [4:0] t;
    t = {w[5] & w[3], w[0], w[1], w[2], w[4]};
    return t[s[3:1]] ^ s[0];
  endfunction
  function automatic logic [7:0] upd(input logic [7:0] w);
    logic [7:0] n;
    n = w;
    case (op_code)
      CCF_OP_ADD, CCF_OP_ADC: n[4] = alu_nib_carry;
      CCF_OP_BTJ: n[0] = bit_test_value;
      CCF_OP_SET_WRAP: n[0] = 1'b1;
      CCF_OP_CLR_WRAP: n[0] = 1'b0;
      CCF_OP_POP, CCF_OP_IRQ_RET: n[5:0] = pop_data[5:0];
      CCF_OP_MASK_ALL: {n[5], n[3]} = PRIO_LVL3;
      CCF_OP_IRQ_ENTRY: {n[5], n[3]} = irq_prio_level;
      CCF_OP_MAIN_LVL, CCF_OP_HALT, CCF_OP_WAIT_IRQ: {n[5], n[3]} = PRIO_LVL0;
      default: ;
    endcase
    if (op_code inside {CCF_OP_ADD, CCF_OP_ADC, CCF_OP_SUB, CCF_OP_LOGIC, CCF_OP_SHIFT})
      {n[2], n[1]} = {alu_result[7], alu_result == 8'h00};
    if (op_code inside {CCF_OP_ADD, CCF_OP_ADC, CCF_OP_SUB, CCF_OP_SHIFT})
      n[0] = alu_carry_out;
    return n;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      exp_b = rst ? 1'b0 : brf(exp_w, br_sel);
      exp_w = rst ? FLAG_WORD_RST : (op_valid ? upd(exp_w) : exp_w);
      repeat (8) seed = lfsr(seed);
      // Ops stay off until one cycle after reset is released, so no update straddles a release.
      rst <= (i < 7) || (i >= 200 && i < 208);
      op_valid <= !rst && seed[3:0] != 4'h0;
      op_code <= ccf_op_e'(seed[7:4]);
      br_sel <= ccf_br_e'(seed[11:8] % 4'd10);
      opa <= seed[19:12];
      opb <= seed[27:20];
      pop_data <= seed[31:24];
      irq_prio_level <= seed[29:28];
      bit_test_value <= seed[30];
      #1;
      if (rst)
        exp_w = FLAG_WORD_RST;
      check(flag_word, exp_w);
      check({7'h00, br_taken}, {7'h00, exp_b && !rst});
      check({7'h00, irq_masked}, {7'h00, exp_w[5] & exp_w[3]});
    end
    stop_test();
  end
endmodule
